// File: src/ddf_top.sv
// Function
// [RULE_01] enable bit 7 clear shuts converter zero
// [RULE_02] control bits 6..3 read zero, ignore writes
// [RULE_03] bits 2..0 select word assembly format
// [RULE_04] code 000: high[3:0] plus full low
// [RULE_05] code 001: high[4:0] plus low[7:1]
// [RULE_06] code 010: high[5:0] plus low[7:2]
// [RULE_07] code 011: high[6:0] plus low[7:3]
// [RULE_08] code 1xx: full high plus low[7:4]
// [RULE_09] converter one behaves identically, own registers
// [RULE_10] word updates only on high byte write
// [RULE_11] software writes low before high
// [RULE_12] software sets bias enable before output
// [RULE_13] reset clears all registers, converters disabled
`timescale 1ns/1ps
`default_nettype none
module ddf_top
    import ddf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic [11:0] conv0_word,
    output logic conv0_enable,
    output logic conv0_load,
    output logic [11:0] conv1_word,
    output logic conv1_enable,
    output logic conv1_load
);
    ddf_chan_if ch0 ();
    ddf_chan_if ch1 ();

    logic [7:0] rdata_r, rdata_nxt;
    logic en0_r, en0_nxt;
    logic en1_r, en1_nxt;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    always_comb begin
        ch0.wdata = sfr_wdata;
        ch1.wdata = sfr_wdata;
        ch0.wr_low = sfr_wr && (sfr_addr == CONV0_DATA_LOW_ADDR);
        ch0.wr_high = sfr_wr && (sfr_addr == CONV0_DATA_HIGH_ADDR);
        ch0.wr_ctrl = sfr_wr && (sfr_addr == CONV0_CONTROL_ADDR);
        ch1.wr_low = sfr_wr && (sfr_addr == CONV1_DATA_LOW_ADDR); // [RULE_09]
        ch1.wr_high = sfr_wr && (sfr_addr == CONV1_DATA_HIGH_ADDR);
        ch1.wr_ctrl = sfr_wr && (sfr_addr == CONV1_CONTROL_ADDR);
    end

    ddf_conv u_conv0 (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ch(ch0.core)
    );

    ddf_conv u_conv1 (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ch(ch1.core)
    );

    // ----------------------------------------
    // read mux and enables
    // ----------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        if (sfr_rd) begin
            case (sfr_addr)
                CONV0_DATA_LOW_ADDR: rdata_nxt = ch0.low;
                CONV0_DATA_HIGH_ADDR: rdata_nxt = ch0.high;
                CONV0_CONTROL_ADDR: rdata_nxt = ch0.ctrl; // [RULE_02]
                CONV1_DATA_LOW_ADDR: rdata_nxt = ch1.low;
                CONV1_DATA_HIGH_ADDR: rdata_nxt = ch1.high;
                CONV1_CONTROL_ADDR: rdata_nxt = ch1.ctrl;
                default: rdata_nxt = UNMAPPED_READ;
            endcase
        end
        // enable follows the stored bit; bias and reference are outside this block
        en0_nxt = ch0.ctrl[CTRL_ENABLE_BIT]; // [RULE_01]
        en1_nxt = ch1.ctrl[CTRL_ENABLE_BIT]; // [RULE_09]
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= REG_RESET; // [RULE_13]
            en0_r <= 1'b0;
            en1_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            en0_r <= en0_nxt;
            en1_r <= en1_nxt;
        end
    end

    assign sfr_rdata = rdata_r;
    assign conv0_enable = en0_r;
    assign conv1_enable = en1_r;
    assign conv0_word = ch0.word;
    assign conv1_word = ch1.word;
    assign conv0_load = ch0.load;
    assign conv1_load = ch1.load;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_enable_follows;
        @(posedge clk_sys) disable iff (!reset_n)
        (sfr_wr && sfr_addr == CONV0_CONTROL_ADDR) |=> ##1
            (conv0_enable == $past(sfr_wdata[7], 2));
    endproperty
    a_enable_follows: assert property (p_enable_follows) // [RULE_01]
        else $error("enable output does not follow control bit");

    property p_conv1_fmt2;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch1.wr_high && ch1.ctrl[2:0] == FMT_SIX_HIGH && !ch1.wr_low)
            |=> (conv1_word == {$past(sfr_wdata[5:0]), ch1.low[7:2]});
    endproperty
    a_conv1_fmt2: assert property (p_conv1_fmt2) // [RULE_06] [RULE_09]
        else $error("converter one format 010 word wrong");

    property p_conv1_fmt3;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch1.wr_high && ch1.ctrl[2:0] == FMT_SEVEN_HIGH && !ch1.wr_low)
            |=> (conv1_word == {$past(sfr_wdata[6:0]), ch1.low[7:3]});
    endproperty
    a_conv1_fmt3: assert property (p_conv1_fmt3) // [RULE_07]
        else $error("converter one format 011 word wrong");

    property p_ctrl_read_unused;
        @(posedge clk_sys) disable iff (!reset_n)
        (sfr_rd && sfr_addr == CONV1_CONTROL_ADDR) |=> (sfr_rdata[6:3] == 4'h0);
    endproperty
    a_ctrl_read_unused: assert property (p_ctrl_read_unused) // [RULE_02]
        else $error("unused control bits read nonzero");

    property p_reset_clear;
        @(posedge clk_sys)
        !$past(reset_n) |-> (conv0_word == WORD_RESET) && !conv0_enable
            && (conv1_word == WORD_RESET) && !conv1_enable;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // [RULE_13]
        else $error("outputs not cleared after reset");

    property p_conv1_enable_follows;
        @(posedge clk_sys) disable iff (!reset_n)
        (sfr_wr && sfr_addr == CONV1_CONTROL_ADDR) |=> ##1
            (conv1_enable == $past(sfr_wdata[CTRL_ENABLE_BIT], 2));
    endproperty
    a_conv1_enable_follows: assert property (p_conv1_enable_follows) // [RULE_09]
        else $error("converter one enable does not follow control bit");

    property p_conv0_off;
        @(posedge clk_sys) disable iff (!reset_n)
        !ch0.ctrl[CTRL_ENABLE_BIT] |=> !conv0_enable;
    endproperty
    a_conv0_off: assert property (p_conv0_off) // [RULE_01]
        else $error("converter zero on while enable bit clear");

    property p_conv1_on;
        @(posedge clk_sys) disable iff (!reset_n)
        ch1.ctrl[CTRL_ENABLE_BIT] |=> conv1_enable;
    endproperty
    a_conv1_on: assert property (p_conv1_on) // [RULE_09]
        else $error("converter one off while enable bit set");

    property p_conv0_fmt2;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch0.wr_high && ch0.ctrl[2:0] == FMT_SIX_HIGH && !ch0.wr_low)
            |=> (conv0_word == {$past(sfr_wdata[5:0]), ch0.low[7:2]});
    endproperty
    a_conv0_fmt2: assert property (p_conv0_fmt2) // [RULE_06]
        else $error("converter zero format 010 word wrong");

    property p_conv0_fmt3;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch0.wr_high && ch0.ctrl[2:0] == FMT_SEVEN_HIGH && !ch0.wr_low)
            |=> (conv0_word == {$past(sfr_wdata[6:0]), ch0.low[7:3]});
    endproperty
    a_conv0_fmt3: assert property (p_conv0_fmt3) // [RULE_07]
        else $error("converter zero format 011 word wrong");

    property p_conv1_fmt0;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch1.wr_high && ch1.ctrl[2:0] == FMT_NYBBLE_HIGH && !ch1.wr_low)
            |=> (conv1_word == {$past(sfr_wdata[3:0]), ch1.low});
    endproperty
    a_conv1_fmt0: assert property (p_conv1_fmt0) // [RULE_04] [RULE_09]
        else $error("converter one format 000 word wrong");

    property p_conv1_fmt1;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch1.wr_high && ch1.ctrl[2:0] == FMT_FIVE_HIGH && !ch1.wr_low)
            |=> (conv1_word == {$past(sfr_wdata[4:0]), ch1.low[7:1]});
    endproperty
    a_conv1_fmt1: assert property (p_conv1_fmt1) // [RULE_05] [RULE_09]
        else $error("converter one format 001 word wrong");

    property p_conv1_fmt_top;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch1.wr_high && ch1.ctrl[2] && !ch1.wr_low)
            |=> (conv1_word == {$past(sfr_wdata), ch1.low[7:4]});
    endproperty
    a_conv1_fmt_top: assert property (p_conv1_fmt_top) // [RULE_08] [RULE_09]
        else $error("converter one format 1xx word wrong");

    property p_ctrl0_read;
        @(posedge clk_sys) disable iff (!reset_n)
        (sfr_rd && sfr_addr == CONV0_CONTROL_ADDR)
            |=> (sfr_rdata == $past(ch0.ctrl)) && (sfr_rdata[6:3] == 4'h0);
    endproperty
    a_ctrl0_read: assert property (p_ctrl0_read) // [RULE_02] [RULE_03]
        else $error("converter zero control read wrong");

    property p_conv0_load_cause;
        @(posedge clk_sys) disable iff (!reset_n)
        conv0_load |-> $past(ch0.wr_high);
    endproperty
    a_conv0_load_cause: assert property (p_conv0_load_cause) // [RULE_10]
        else $error("converter zero loaded without high byte write");

    property p_conv1_low_holds;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch1.wr_low && !ch1.wr_high) |=> (conv1_word == $past(conv1_word));
    endproperty
    a_conv1_low_holds: assert property (p_conv1_low_holds) // [RULE_10] [RULE_09]
        else $error("converter one low byte write changed the word");

    c_conv0_enable: cover property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(conv0_enable));
    c_conv1_top_fmt: cover property (@(posedge clk_sys) disable iff (!reset_n)
        ch1.wr_high && ch1.ctrl[2]);
    c_unmapped_read: cover property (@(posedge clk_sys) disable iff (!reset_n)
        sfr_rd && sfr_addr == 8'h00);
endmodule
`default_nettype wire

// File: src/ddf_pkg.sv
`default_nettype none
package ddf_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [7:0] CONV0_DATA_LOW_ADDR = 8'hD2;
    localparam logic [7:0] CONV0_DATA_HIGH_ADDR = 8'hD3;
    localparam logic [7:0] CONV0_CONTROL_ADDR = 8'hD4;
    localparam logic [7:0] CONV1_DATA_LOW_ADDR = 8'hD5;
    localparam logic [7:0] CONV1_DATA_HIGH_ADDR = 8'hD6;
    localparam logic [7:0] CONV1_CONTROL_ADDR = 8'hD7;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_FMT_MSB = 2;
    localparam int CTRL_FMT_LSB = 0;
    localparam logic [7:0] CTRL_WRITABLE_MASK = 8'h87;

    // ----------------------------------------
    // format codes and reset values
    // ----------------------------------------
    localparam logic [2:0] FMT_NYBBLE_HIGH = 3'h0;
    localparam logic [2:0] FMT_FIVE_HIGH = 3'h1;
    localparam logic [2:0] FMT_SIX_HIGH = 3'h2;
    localparam logic [2:0] FMT_SEVEN_HIGH = 3'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [11:0] WORD_RESET = 12'h000;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // builds the 12-bit word from the two data bytes for a given format
    function automatic logic [11:0] ddf_assemble(input logic [7:0] high,
                                                 input logic [7:0] low,
                                                 input logic [2:0] fmt);
        logic [11:0] w;
        w = {high[3:0], low};
        if (fmt[2]) begin
            w = {high, low[7:4]}; // [RULE_08]
        end else begin
            case (fmt[1:0])
                FMT_NYBBLE_HIGH[1:0]: w = {high[3:0], low}; // [RULE_04]
                FMT_FIVE_HIGH[1:0]: w = {high[4:0], low[7:1]}; // [RULE_05]
                FMT_SIX_HIGH[1:0]: w = {high[5:0], low[7:2]}; // [RULE_06]
                FMT_SEVEN_HIGH[1:0]: w = {high[6:0], low[7:3]}; // [RULE_07]
                default: w = {high[3:0], low};
            endcase
        end
        return w;
    endfunction
endpackage
`default_nettype wire

// File: src/ddf_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ddf_chan_if;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic [7:0] wdata;
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] ctrl;
    logic [11:0] word;
    logic load;
    modport core (input wr_low, input wr_high, input wr_ctrl, input wdata,
                  output low, output high, output ctrl, output word, output load);
    modport ctl (output wr_low, output wr_high, output wr_ctrl, output wdata,
                 input low, input high, input ctrl, input word, input load);
endinterface
`default_nettype wire

// File: src/ddf_conv.sv
`timescale 1ns/1ps
`default_nettype none
module ddf_conv
    import ddf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    ddf_chan_if.core ch
);
    logic [7:0] low_r, low_nxt;
    logic [7:0] high_r, high_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [11:0] word_r, word_nxt;
    logic load_r, load_nxt;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        low_nxt = low_r;
        high_nxt = high_r;
        ctrl_nxt = ctrl_r;
        word_nxt = word_r;
        load_nxt = 1'b0;
        if (ch.wr_low) begin
            low_nxt = ch.wdata;
        end
        if (ch.wr_ctrl) begin
            ctrl_nxt = ch.wdata & CTRL_WRITABLE_MASK; // [RULE_02]
        end
        // only a high-byte write moves the output; low is staged until then
        if (ch.wr_high) begin
            high_nxt = ch.wdata;
            word_nxt = ddf_assemble(ch.wdata, low_nxt,
                                    ctrl_r[CTRL_FMT_MSB:CTRL_FMT_LSB]); // [RULE_10] [RULE_03]
            load_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            low_r <= REG_RESET; // [RULE_13]
            high_r <= REG_RESET;
            ctrl_r <= REG_RESET;
            word_r <= WORD_RESET;
            load_r <= 1'b0;
        end else begin
            low_r <= low_nxt;
            high_r <= high_nxt;
            ctrl_r <= ctrl_nxt;
            word_r <= word_nxt;
            load_r <= load_nxt;
        end
    end

    assign ch.low = low_r;
    assign ch.high = high_r;
    assign ch.ctrl = ctrl_r;
    assign ch.word = word_r;
    assign ch.load = load_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_low_holds_word;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch.wr_low && !ch.wr_high) |=> (word_r == $past(word_r));
    endproperty
    a_low_holds_word: assert property (p_low_holds_word) // [RULE_10]
        else $error("low byte write changed the word");

    property p_fmt0_layout;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch.wr_high && ctrl_r[2:0] == FMT_NYBBLE_HIGH && !ch.wr_low)
            |=> (word_r == {$past(ch.wdata[3:0]), low_r});
    endproperty
    a_fmt0_layout: assert property (p_fmt0_layout) // [RULE_04]
        else $error("format 000 word wrong");

    property p_fmt1_layout;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch.wr_high && ctrl_r[2:0] == FMT_FIVE_HIGH && !ch.wr_low)
            |=> (word_r == {$past(ch.wdata[4:0]), low_r[7:1]});
    endproperty
    a_fmt1_layout: assert property (p_fmt1_layout) // [RULE_05]
        else $error("format 001 word wrong");

    property p_fmt_top_layout;
        @(posedge clk_sys) disable iff (!reset_n)
        (ch.wr_high && ctrl_r[2] && !ch.wr_low)
            |=> (word_r == {$past(ch.wdata), low_r[7:4]});
    endproperty
    a_fmt_top_layout: assert property (p_fmt_top_layout) // [RULE_08]
        else $error("format 1xx word wrong");

    property p_unused_zero;
        @(posedge clk_sys) disable iff (!reset_n)
        ch.wr_ctrl |=> (ctrl_r[6:3] == 4'h0) && (ctrl_r[2:0] == $past(ch.wdata[2:0]));
    endproperty
    a_unused_zero: assert property (p_unused_zero) // [RULE_02]
        else $error("unused control bits not zero");

    property p_load_pulse;
        @(posedge clk_sys) disable iff (!reset_n)
        ch.wr_high |=> load_r ##1 (load_r == $past(ch.wr_high));
    endproperty
    a_load_pulse: assert property (p_load_pulse) // [RULE_10]
        else $error("load pulse wrong");

    c_fmt2_load: cover property (@(posedge clk_sys) disable iff (!reset_n)
        ch.wr_high && ctrl_r[2:0] == FMT_SIX_HIGH);
    c_low_then_high: cover property (@(posedge clk_sys) disable iff (!reset_n)
        ch.wr_low ##1 ch.wr_high);
endmodule
`default_nettype wire

// File: verif/ddf_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddf_cpu_model (
    input wire logic clk_sys,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic sfr_wr,
    output logic sfr_rd,
    input wire logic [7:0] sfr_rdata
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    end

    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        sfr_wr = 1'b0;
        // idle bus shows the inverse so a stale value cannot pass as held
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        d = sfr_rdata;
    endtask

    // low byte always goes first so the high write latches all twelve bits
    task automatic load_pair(input logic [7:0] al, input logic [7:0] l,
                             input logic [7:0] ah, input logic [7:0] h);
        wr(al, l);
        wr(ah, h);
    endtask
    // bias_enable in reference_control lives outside this block and is
    // assumed already set by software
endmodule
`default_nettype wire

// File: verif/tb_dual_dac_data_format_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_dac_data_format_control;
    import ddf_pkg::*;
    logic clk_sys;
    logic reset_n;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_rdata;
    logic [11:0] conv0_word;
    logic conv0_enable;
    logic conv0_load;
    logic [11:0] conv1_word;
    logic conv1_enable;
    logic conv1_load;
    int num_errors = 0;
    int compares = 0;
    int lo[2];
    int hi[2];
    int ct[2];
    int wd[2];

    ddf_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .conv0_word(conv0_word), .conv0_enable(conv0_enable), .conv0_load(conv0_load),
        .conv1_word(conv1_word), .conv1_enable(conv1_enable), .conv1_load(conv1_load));
    ddf_cpu_model cpu (.clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // reference model and checks
    // ----------------------------------------
    function automatic int mdl_word(int h, int l, int f);
        if (f >= 4) return h * 16 + l / 16;
        return (h % (1 << (4 + f))) * (1 << (8 - f)) + l / (1 << f);
    endfunction

    function automatic int mdl_rd(logic [7:0] a);
        case (a)
            CONV0_DATA_LOW_ADDR: return lo[0];
            CONV0_DATA_HIGH_ADDR: return hi[0];
            CONV0_CONTROL_ADDR: return ct[0];
            CONV1_DATA_LOW_ADDR: return lo[1];
            CONV1_DATA_HIGH_ADDR: return hi[1];
            CONV1_CONTROL_ADDR: return ct[1];
            default: return 0;
        endcase
    endfunction

    task automatic chk_rd(string name, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_out(string name, logic [12:0] exp, logic [12:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_cleared();
        chk_out("conv0 word and load", 13'h0000, {conv0_word, conv0_load});
        chk_out("conv1 word and load", 13'h0000, {conv1_word, conv1_load});
        chk_out("enables", 13'h0000, 13'({conv0_enable, conv1_enable}));
        chk_rd("read data", 8'h00, sfr_rdata);
    endtask

    task automatic chk_all_regs();
        logic [7:0] d;
        for (int a = 'hD0; a <= 'hD9; a++) begin
            cpu.rd(8'(a), d);
            chk_rd("register read", 8'(mdl_rd(8'(a))), d);
        end
    endtask

    task automatic final_report();
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #400000;
        num_errors++;
        final_report();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] c;
        logic [7:0] l;
        logic [7:0] h;
        logic [7:0] base;
        reset_n = 1'b0;
        foreach (lo[i]) begin
            lo[i] = 0;
            hi[i] = 0;
            ct[i] = 0;
            wd[i] = 0;
        end
        void'($urandom(18751));
        repeat (12) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        chk_cleared();
        chk_all_regs();
        for (int ch = 0; ch < 2; ch++) begin
            base = ch ? CONV1_DATA_LOW_ADDR : CONV0_DATA_LOW_ADDR;
            for (int f = 0; f < 8; f++) begin
                c = 8'($urandom());
                c[2:0] = 3'(f);
                cpu.wr(base + 8'h02, c);
                ct[ch] = int'(c & CTRL_WRITABLE_MASK);
                cpu.rd(base + 8'h02, d);
                chk_rd("control readback", 8'(ct[ch]), d);
                chk_out("enable", 13'(c[7]), ch ? conv1_enable : conv0_enable);
                l = 8'($urandom());
                cpu.wr(base, l);
                lo[ch] = l;
                chk_out("word after low only", 13'(wd[ch] * 2),
                        ch ? {conv1_word, conv1_load} : {conv0_word, conv0_load});
                h = 8'($urandom());
                cpu.wr(base + 8'h01, h);
                hi[ch] = h;
                wd[ch] = mdl_word(h, l, f);
                chk_out("word and load", 13'(wd[ch] * 2 + 1),
                        ch ? {conv1_word, conv1_load} : {conv0_word, conv0_load});
            end
            l = 8'($urandom());
            h = 8'($urandom());
            cpu.load_pair(base, l, base + 8'h01, h);
            lo[ch] = l;
            hi[ch] = h;
            wd[ch] = mdl_word(h, l, ct[ch] % 8);
            chk_out("paired load", 13'(wd[ch]), ch ? conv1_word : conv0_word);
        end
        cpu.wr(8'hD8, 8'($urandom()));
        cpu.wr(8'hD1, 8'($urandom()));
        chk_all_regs();
        // second reset with both converters loaded, so clearing is really exercised
        reset_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk_cleared();
        reset_n = 1'b1;
        foreach (lo[i]) begin
            lo[i] = 0;
            hi[i] = 0;
            ct[i] = 0;
            wd[i] = 0;
        end
        repeat (2) @(posedge clk_sys);
        #1;
        chk_cleared();
        chk_all_regs();
        final_report();
    end
endmodule
`default_nettype wire
